// ### timer_compare_regs.vh
`ifndef TIMER_COMPARE_REGS_VH
`define TIMER_COMPARE_REGS_VH

// ----------------------------------------------------------------
// register byte offsets (lower channel m, upper channel m+1)
// ----------------------------------------------------------------
`define CTRL_LO_OFFSET      8'h00
`define VALUE_LO_OFFSET     8'h04
`define CTRL_HI_OFFSET      8'h08
`define VALUE_HI_OFFSET     8'h0c

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define CHANNEL_MODE_BIT    0
`define POLARITY_BIT        1
`define GEN_MODE_LSB        2
`define GEN_MODE_MSB        4
`define SW_LEVEL_BIT        5
`define PAIRED_BIT          6
`define CTRL_WRITE_MASK     16'hff7f
`define CTRL_RESET          16'h0000
`define VALUE_RESET         16'h0000

// ----------------------------------------------------------------
// generation modes
// ----------------------------------------------------------------
`define GEN_SOFTWARE        3'h0
`define GEN_SET             3'h1
`define GEN_TOGGLE_RESET    3'h2
`define GEN_SET_RESET       3'h3
`define GEN_TOGGLE          3'h4
`define GEN_RESET           3'h5
`define GEN_TOGGLE_SET      3'h6
`define GEN_RESET_SET       3'h7

// ----------------------------------------------------------------
// count modes and bus answers
// ----------------------------------------------------------------
`define COUNT_UP            2'h0
`define COUNT_DOWN          2'h1
`define COUNT_UP_DOWN       2'h2
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ### compare_capture_unit.v
`timescale 1ns/10ps
`include "timer_compare_regs.vh"

module compare_capture_unit (
   input  wire        clk,
   input  wire        rstN,
   input  wire        captureMode,
   input  wire        wrEn,
   input  wire [15:0] wrData,
   input  wire [1:0]  wrStrb,
   input  wire [15:0] counterValue,
   input  wire        counterTick,
   input  wire        captureTrigger,
   output reg  [15:0] valueQ,
   output reg         hitQ
);

   // ----------------------------------------------------------------
   // compare/capture data word
   // ----------------------------------------------------------------
   // a capture in the same cycle as a software write wins: the counter
   // sample is the fresher fact
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         valueQ <= `VALUE_RESET;
      end else if (captureMode && captureTrigger) begin
         valueQ <= counterValue;
      end else if (wrEn) begin
         if (wrStrb[0]) begin
            valueQ[7:0] <= wrData[7:0];
         end
         if (wrStrb[1]) begin
            valueQ[15:8] <= wrData[15:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // compare hit, one clock per counter step that lands on the value
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         hitQ <= 1'b0;
      end else begin
         hitQ <= !captureMode && counterTick && (counterValue == valueQ);
      end
   end

endmodule // compare_capture_unit

// ### output_wave_gen.v
`timescale 1ns/10ps
`include "timer_compare_regs.vh"

module output_wave_gen (
   input  wire       clk,
   input  wire       rstN,
   input  wire       captureMode,
   input  wire [2:0] genMode,
   input  wire       paired,
   input  wire       swLevel,
   input  wire       polarity,
   input  wire       countDown,
   input  wire       ownHit,
   input  wire       partnerHit,
   input  wire       maxEvent,
   input  wire       zeroEvent,
   output reg        timerOutput
);

   reg  activeQ;
   reg  activeD;
   wire periodEvent;
   wire firstEvent;
   wire secondEvent;
   wire singleAction;

   // ----------------------------------------------------------------
   // event selection
   // ----------------------------------------------------------------
   assign periodEvent  = countDown ? zeroEvent : maxEvent;
   assign singleAction = (genMode == `GEN_SET) || (genMode == `GEN_TOGGLE) ||
                         (genMode == `GEN_RESET);
   assign firstEvent   = (paired && singleAction) ? (ownHit || partnerHit) : ownHit;
   assign secondEvent  = paired ? partnerHit : periodEvent;

   // ----------------------------------------------------------------
   // active-level state; second action first, hit action last
   // ----------------------------------------------------------------
   always @* begin
      activeD = activeQ;
      case (genMode)
         `GEN_SOFTWARE: begin
            activeD = swLevel;
         end
         `GEN_SET: begin
            if (firstEvent) activeD = 1'b1;
         end
         `GEN_TOGGLE_RESET: begin
            if (secondEvent) activeD = 1'b0;
            if (firstEvent) activeD = ~activeD;
         end
         `GEN_SET_RESET: begin
            if (secondEvent) activeD = 1'b0;
            if (firstEvent) activeD = 1'b1;
         end
         `GEN_TOGGLE: begin
            if (firstEvent) activeD = ~activeQ;
         end
         `GEN_RESET: begin
            if (firstEvent) activeD = 1'b0;
         end
         `GEN_TOGGLE_SET: begin
            if (secondEvent) activeD = 1'b1;
            if (firstEvent) activeD = ~activeD;
         end
         default: begin
            if (secondEvent) activeD = 1'b1;
            if (firstEvent) activeD = 1'b0;
         end
      endcase
   end

   // capture mode freezes the state and parks the pin low
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         activeQ     <= 1'b0;
         timerOutput <= 1'b0;
      end else if (captureMode) begin
         timerOutput <= 1'b0;
      end else begin
         activeQ     <= activeD;
         timerOutput <= activeD ^ polarity;
      end
   end

endmodule // output_wave_gen

// ### timer_compare_output_gen.v
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "timer_compare_regs.vh"

module timer_compare_output_gen (
   input  wire        clk,
   input  wire        reset_n,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [15:0] counterValue,
   input  wire        counterTick,
   input  wire [1:0]  countMode,
   input  wire        maxEvent,
   input  wire        zeroEvent,
   input  wire        captureTriggerLo,
   input  wire        captureTriggerHi,
   output wire        timerOutputLo,
   output wire        timerOutputHi
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   reg  [1:0]  rstSyncQ;
   wire        rstN;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstSyncQ <= 2'b00;
      end else begin
         rstSyncQ <= {rstSyncQ[0], 1'b1};
      end
   end
   assign rstN = rstSyncQ[1];

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   reg  [15:0] ctrlLoQ;
   reg  [15:0] ctrlHiQ;
   reg  [7:0]  awAddrQ;
   reg         awHeldQ;
   reg  [31:0] wDataQ;
   reg  [3:0]  wStrbQ;
   reg         wHeldQ;
   reg         maxEventQ;
   reg         zeroEventQ;
   wire        doWrite;
   wire [15:0] valueLo;
   wire [15:0] valueHi;
   wire        hitLo;
   wire        hitHi;
   wire        captureLo;
   wire        captureHi;
   wire        countDown;

   // write when both halves of the request are held and no answer waits
   assign doWrite   = awHeldQ && wHeldQ && !s_axi_bvalid;
   assign captureLo = ctrlLoQ[`CHANNEL_MODE_BIT];
   assign captureHi = ctrlHiQ[`CHANNEL_MODE_BIT];
   assign countDown = (countMode == `COUNT_DOWN);

   function [15:0] mergeBytes;
      input [15:0] old;
      input [15:0] data;
      input [1:0]  strb;
      begin
         mergeBytes = {strb[1] ? data[15:8] : old[15:8],
                       strb[0] ? data[7:0]  : old[7:0]};
      end
   endfunction

   function mapped;
      input [7:0] addr;
      begin
         if (addr == `CTRL_LO_OFFSET) mapped = 1'b1;
         else if (addr == `VALUE_LO_OFFSET) mapped = 1'b1;
         else if (addr == `CTRL_HI_OFFSET) mapped = 1'b1;
         else if (addr == `VALUE_HI_OFFSET) mapped = 1'b1;
         else mapped = 1'b0;
      end
   endfunction

   // ----------------------------------------------------------------
   // write address and data channels, taken in either order
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         awHeldQ       <= 1'b0;
         wHeldQ        <= 1'b0;
         awAddrQ       <= 8'h00;
         wDataQ        <= 32'h00000000;
         wStrbQ        <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddrQ       <= s_axi_awaddr;
            awHeldQ       <= 1'b1;
            s_axi_awready <= 1'b0;
         end else if (doWrite) begin
            awHeldQ <= 1'b0;
         end else if (!awHeldQ && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wDataQ       <= s_axi_wdata;
            wStrbQ       <= s_axi_wstrb;
            wHeldQ       <= 1'b1;
            s_axi_wready <= 1'b0;
         end else if (doWrite) begin
            wHeldQ <= 1'b0;
         end else if (!wHeldQ && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // write response
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(awAddrQ) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // bits 15:8 are stored only for read-back and bit 7 always reads zero;
   // buffer load timing and trigger selection live in the counter core
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ctrlLoQ <= `CTRL_RESET;
         ctrlHiQ <= `CTRL_RESET;
      end else if (doWrite) begin
         if (awAddrQ == `CTRL_LO_OFFSET) begin
            ctrlLoQ <= mergeBytes(ctrlLoQ, wDataQ[15:0], wStrbQ[1:0]) & `CTRL_WRITE_MASK;
         end else if (awAddrQ == `CTRL_HI_OFFSET) begin
            ctrlHiQ <= mergeBytes(ctrlHiQ, wDataQ[15:0], wStrbQ[1:0]) & `CTRL_WRITE_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `RESP_OKAY;
         if (s_axi_araddr == `CTRL_LO_OFFSET) begin
            s_axi_rdata <= {16'h0000, ctrlLoQ};
         end else if (s_axi_araddr == `VALUE_LO_OFFSET) begin
            s_axi_rdata <= {16'h0000, valueLo};
         end else if (s_axi_araddr == `CTRL_HI_OFFSET) begin
            s_axi_rdata <= {16'h0000, ctrlHiQ};
         end else if (s_axi_araddr == `VALUE_HI_OFFSET) begin
            s_axi_rdata <= {16'h0000, valueHi};
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // period events delayed to line up with the registered hits
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         maxEventQ  <= 1'b0;
         zeroEventQ <= 1'b0;
      end else begin
         maxEventQ  <= maxEvent;
         zeroEventQ <= zeroEvent;
      end
   end

   // ----------------------------------------------------------------
   // compare/capture units
   // ----------------------------------------------------------------
   compare_capture_unit unitLo (
      .clk            (clk),
      .rstN           (rstN),
      .captureMode    (captureLo),
      .wrEn           (doWrite && (awAddrQ == `VALUE_LO_OFFSET)),
      .wrData         (wDataQ[15:0]),
      .wrStrb         (wStrbQ[1:0]),
      .counterValue   (counterValue),
      .counterTick    (counterTick),
      .captureTrigger (captureTriggerLo),
      .valueQ         (valueLo),
      .hitQ           (hitLo)
   );

   compare_capture_unit unitHi (
      .clk            (clk),
      .rstN           (rstN),
      .captureMode    (captureHi),
      .wrEn           (doWrite && (awAddrQ == `VALUE_HI_OFFSET)),
      .wrData         (wDataQ[15:0]),
      .wrStrb         (wStrbQ[1:0]),
      .counterValue   (counterValue),
      .counterTick    (counterTick),
      .captureTrigger (captureTriggerHi),
      .valueQ         (valueHi),
      .hitQ           (hitHi)
   );

   // ----------------------------------------------------------------
   // output generators; each sees the other channel's hit as partner
   // ----------------------------------------------------------------
   output_wave_gen genLo (
      .clk         (clk),
      .rstN        (rstN),
      .captureMode (captureLo),
      .genMode     (ctrlLoQ[`GEN_MODE_MSB:`GEN_MODE_LSB]),
      .paired      (ctrlLoQ[`PAIRED_BIT]),
      .swLevel     (ctrlLoQ[`SW_LEVEL_BIT]),
      .polarity    (ctrlLoQ[`POLARITY_BIT]),
      .countDown   (countDown),
      .ownHit      (hitLo),
      .partnerHit  (hitHi),
      .maxEvent    (maxEventQ),
      .zeroEvent   (zeroEventQ),
      .timerOutput (timerOutputLo)
   );

   output_wave_gen genHi (
      .clk         (clk),
      .rstN        (rstN),
      .captureMode (captureHi),
      .genMode     (ctrlHiQ[`GEN_MODE_MSB:`GEN_MODE_LSB]),
      .paired      (ctrlHiQ[`PAIRED_BIT]),
      .swLevel     (ctrlHiQ[`SW_LEVEL_BIT]),
      .polarity    (ctrlHiQ[`POLARITY_BIT]),
      .countDown   (countDown),
      .ownHit      (hitHi),
      .partnerHit  (hitLo),
      .maxEvent    (maxEventQ),
      .zeroEvent   (zeroEventQ),
      .timerOutput (timerOutputHi)
   );

endmodule // timer_compare_output_gen

// ### compare_out_asserts.sv
`timescale 1ns/10ps
module compare_out_asserts (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        counterTick,
   input wire logic        maxEvent,
   input wire logic        zeroEvent,
   input wire logic        timerOutputLo,
   input wire logic        timerOutputHi
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // --------
   // register bus
   // --------
   a_ar_refuse: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
      else $error("arready high right after address taken");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000) else $error("read answer late");
   a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0c
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_aw_refuse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*3])
      else $error("awready back too soon");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready while write answer pending");
   a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid) else $error("write answer not two edges after data");
   // --------
   // pins move only after an event or a register write
   // --------
   a_pin_cause: assert property ($changed(timerOutputLo) || $changed(timerOutputHi) |->
      $past(counterTick, 2) || $past(maxEvent, 2) || $past(zeroEvent, 2)
      || $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2)) else $error("pin moved uncaused");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
   cover property ($rose(timerOutputLo));
   cover property ($rose(timerOutputHi));
endmodule // compare_out_asserts

bind timer_compare_output_gen compare_out_asserts chk (
   .clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .counterTick, .maxEvent, .zeroEvent, .timerOutputLo, .timerOutputHi
);

// ### pin_load_model.sv
`timescale 1ns/10ps
module pin_load_model (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       timerOutputLo,
   input  wire logic       timerOutputHi,
   output logic      [7:0] riseLo,
   output logic      [7:0] riseHi
);
   // --------
   // load sees the pins only; rise counts expose doubled or missed pulses
   // --------
   logic lastLoQ, lastHiQ;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lastLoQ <= 1'b0;
         lastHiQ <= 1'b0;
         riseLo <= 8'h00;
         riseHi <= 8'h00;
      end else begin
         lastLoQ <= timerOutputLo;
         lastHiQ <= timerOutputHi;
         riseLo <= riseLo + {7'h00, timerOutputLo & ~lastLoQ};
         riseHi <= riseHi + {7'h00, timerOutputHi & ~lastHiQ};
      end
   end
endmodule // pin_load_model

// ### tb_timer_compare_output_gen.sv
`timescale 1ns/10ps
`include "timer_compare_regs.vh"
module tb_timer_compare_output_gen;
   logic        clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, counterTick, maxEvent, zeroEvent, captureTriggerLo;
   logic        captureTriggerHi, timerOutputLo, timerOutputHi, stLo;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, riseLo, riseHi;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, countMode, rsp;
   logic [15:0] counterValue;
   int          fails = 0, n_checks = 0, cyc = 0;
   // paired rows: both controls, counter value, expected lo/hi pins
   logic [7:0]  pc [0:6] = '{8'h5c, 8'h5c, 8'h5c, 8'h4c, 8'h50, 8'h54, 8'h44};
   logic [15:0] pv [0:6] = '{16'h0010, 16'hffff, 16'h0020, 16'h0020, 16'h0010, 16'h0020, 16'h0010};
   logic [1:0]  pe [0:6] = '{2'b01, 2'b01, 2'b10, 2'b01, 2'b10, 2'b00, 2'b11};

   timer_compare_output_gen dut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .counterValue, .counterTick, .countMode, .maxEvent, .zeroEvent, .captureTriggerLo,
      .captureTriggerHi, .timerOutputLo, .timerOutputHi);
   pin_load_model load (.clk, .reset_n, .timerOutputLo, .timerOutputHi, .riseLo, .riseHi);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // --------
   // checking and closing
   // --------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         stop_test;
      end
   end
   // --------
   // bus master; ready raised late so the answer must stand
   // --------
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge clk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      #1;
   endtask
   task rd_reg(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge clk);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // counter step with optional max/zero; pins settle two edges later
   task ev(input logic [15:0] cv, input logic mx, input logic zr);
      @(posedge clk);
      counterValue <= cv;
      counterTick <= 1'b1;
      maxEvent <= mx;
      zeroEvent <= zr;
      @(posedge clk);
      counterTick <= 1'b0;
      maxEvent <= 1'b0;
      zeroEvent <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   function logic nxt(input logic [2:0] m, input logic s, input logic e, input logic h);
      logic r;
      r = s;
      if (e && (m == 3'h7 || m == 3'h6)) r = 1'b1;
      if (e && (m == 3'h3 || m == 3'h2)) r = 1'b0;
      if (h && (m == 3'h7 || m == 3'h5)) r = 1'b0;
      if (h && (m == 3'h6 || m == 3'h4 || m == 3'h2)) r = ~r;
      if (h && (m == 3'h3 || m == 3'h1)) r = 1'b1;
      return r;
   endfunction
   // --------
   // main sequence
   // --------
   initial begin
      {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {counterTick, maxEvent, zeroEvent, captureTriggerLo, captureTriggerHi} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, counterValue, countMode} = 0;
      s_axi_wstrb = 4'hf;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      rd_reg(`CTRL_LO_OFFSET);
      chk(rd, {16'h0000, `CTRL_RESET});
      rd_reg(`VALUE_HI_OFFSET);
      chk(rd, {16'h0000, `VALUE_RESET});
      rd_reg(8'h10);
      chk({rsp, rd[29:0]}, {`RESP_SLVERR, 30'h0});
      wr(8'h10, 16'h1234);
      chk(rsp, `RESP_SLVERR);
      wr(`CTRL_HI_OFFSET, 16'hff80);
      rd_reg(`CTRL_HI_OFFSET);
      chk({rsp, rd[29:0]}, {`RESP_OKAY, 30'h0000ff00});
      wr(`CTRL_HI_OFFSET, 16'h0000);
      wr(`VALUE_LO_OFFSET, 16'h0010);
      wr(`VALUE_HI_OFFSET, 16'h0020);
      rd_reg(`VALUE_LO_OFFSET);
      chk(rd, 32'h0000_0010);
      // every unpaired mode except software in every count mode; wrong end event must not act
      stLo = 1'b0;
      for (int c = 0; c < 3; c++) begin
         countMode <= c[1:0];
         for (int m = 1; m < 8; m++) begin
            wr(`CTRL_LO_OFFSET, {11'h000, m[2:0], 2'b00});
            ev(16'hfff0, c == 1, c != 1);
            chk(timerOutputLo, stLo);
            ev(16'hffff, c != 1, c == 1);
            stLo = nxt(m[2:0], stLo, 1'b1, 1'b0);
            chk(timerOutputLo, stLo);
            ev(16'h0010, 1'b0, 1'b0);
            stLo = nxt(m[2:0], stLo, 1'b0, 1'b1);
            chk(timerOutputLo, stLo);
            ev(16'h0010, c != 1, c == 1);
            stLo = nxt(m[2:0], stLo, 1'b1, 1'b1);
            chk(timerOutputLo, stLo);
         end
      end
      chk(timerOutputHi, 1'b0);
      countMode <= 2'h0;
      for (int i = 0; i < 7; i++) begin
         wr(`CTRL_LO_OFFSET, {8'h00, pc[i]});
         wr(`CTRL_HI_OFFSET, {8'h00, pc[i]});
         ev(pv[i], pv[i] == 16'hffff, 1'b0);
         chk({timerOutputLo, timerOutputHi}, pe[i]);
      end
      @(posedge clk);
      #1;
      chk(riseHi, 8'h03);
      wr(`CTRL_HI_OFFSET, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr(`CTRL_LO_OFFSET, {10'h000, i[0], 3'h0, i[1], 1'b0});
         chk(timerOutputLo, i[0] ^ i[1]);
      end
      // capture mode with level, polarity set: they must not reach the pin
      wr(`CTRL_LO_OFFSET, 16'h0023);
      chk(timerOutputLo, 1'b0);
      ev(16'h0010, 1'b0, 1'b0);
      chk(timerOutputLo, 1'b0);
      @(posedge clk);
      counterValue <= 16'habcd;
      captureTriggerLo <= 1'b1;
      captureTriggerHi <= 1'b1;
      @(posedge clk);
      captureTriggerLo <= 1'b0;
      captureTriggerHi <= 1'b0;
      rd_reg(`VALUE_LO_OFFSET);
      chk(rd, 32'h0000_abcd);
      rd_reg(`VALUE_HI_OFFSET);
      chk(rd, 32'h0000_0020);
      stop_test;
   end
endmodule // tb_timer_compare_output_gen
